/* shared/column_driver_pkg.sv */
package column_driver_pkg;

  // ************************************************************
  // pixel path geometry
  // ************************************************************
  localparam int WORD_W     = 10;                 // pixel word width, msb is bit 9
  localparam int CH_COUNT   = 12;                 // channel latches
  localparam int PAIR_COUNT = 6;                  // clocks per loading sequence
  localparam int FRAME_W    = CH_COUNT * WORD_W + 1;
  localparam int BUF_DEPTH  = 2;                  // output buffer entries

  // ************************************************************
  // serial dac path
  // ************************************************************
  localparam int SER_W        = 12;               // serial word width
  localparam int SER_MIN_CLKS = 3;                // least serial clocks for a valid load

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [2:0]       PAIR_IDLE_RST = 3'h6;
  localparam logic [WORD_W-1:0] WORD_RST     = 10'h000;
  localparam logic [SER_W-1:0]  SER_RST      = 12'h000;

endpackage

/* rtl/frame_skid_buffer.sv */
module frame_skid_buffer
  import column_driver_pkg::*;
#(
  parameter int W     = FRAME_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] wr_ptr_nxt;
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] rd_ptr_nxt;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          push;
  logic          pop;

  // ************************************************************
  // flags and pointer steps
  // ************************************************************
  assign in_ready  = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next pointers and fill level
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
    end
    if (push && !pop) begin
      count_nxt = count_r + CW'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CW'(1);
    end
  end

  // pointer registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // storage, cleared at reset so the buffer shows zeros until each entry is first written
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule

/* rtl/column_driver_input.sv */
// Operation
// - strobe sampled only on rising clock edges
// - edge after strobe moves data, restarts loading; strobe ignored while output buffer full
// - select low ascends from 0, high descends
// - invert input captured on first edge after strobe
// - pending polarity applied at next strobe
// - polarity high means outputs above center
// - thermal protection follows thermal switch input
// - aux dac output updates on enable rise; only after at least 3 serial clocks
// - six clocks load twelve words, both edges
// - ten-bit pixel bus, bit 9 most significant
// - serial word shifts while enable low
module column_driver_input
  import column_driver_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic [WORD_W-1:0]          pixel_data_bus,
  input  wire logic                       transfer_start_strobe,
  input  wire logic                       load_dir_select,
  input  wire logic                       polarity_invert,
  input  wire logic                       thermal_protect_enable,
  input  wire logic                       serial_clock,
  input  wire logic                       serial_load_enable,
  input  wire logic                       serial_data_in,
  output logic                            frame_ready,
  output logic                            video_valid,
  input  wire logic                       video_ready,
  output logic [CH_COUNT*WORD_W-1:0]      video_output,
  output logic                            video_above_center,
  output logic                            thermal_protect_active,
  output logic [SER_W-1:0]                aux_dac_output,
  output logic                            aux_dac_update
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [WORD_W-1:0] chan_r [CH_COUNT];
  logic [WORD_W-1:0] chan_nxt [CH_COUNT];
  logic [WORD_W-1:0] rise_word_r;
  logic [WORD_W-1:0] fall_word_r;
  logic [2:0]        pair_cnt_r;
  logic [2:0]        pair_cnt_nxt;
  logic              load_dir_r;
  logic              load_dir_nxt;
  logic              strobe_seen_r;
  logic              pending_pol_r;
  logic              pending_pol_nxt;
  logic              applied_pol_r;
  logic              applied_pol_nxt;
  logic              started_r;
  logic              xfer_take;
  logic [FRAME_W-1:0] frame_in;
  logic [FRAME_W-1:0] frame_out;
  logic              buf_in_ready;

  logic [1:0]        therm_sync_r;
  logic [2:0]        sclk_sync_r;
  logic [2:0]        load_en_sync_r;
  logic [1:0]        sdata_sync_r;
  logic              sclk_rise;
  logic              load_en_rise;
  logic              load_en_fall;
  logic [SER_W-1:0]  shift_r;
  logic [SER_W-1:0]  shift_nxt;
  logic [1:0]        sclk_cnt_r;
  logic [1:0]        sclk_cnt_nxt;
  logic [SER_W-1:0]  aux_nxt;
  logic              aux_upd_nxt;

  // channel index for a slot in the current direction
  function automatic logic [3:0] chan_index(input logic dir, input logic [3:0] slot);
    chan_index = dir ? 4'(CH_COUNT - 1) - slot : slot;
  endfunction

  // ************************************************************
  // pixel capture
  // ************************************************************
  // falling-edge half of the double-rate bus
  always_ff @(negedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fall_word_r <= WORD_RST;
    end else begin
      fall_word_r <= pixel_data_bus;
    end
  end

  // transfer accepted only when the output buffer has room
  assign xfer_take   = strobe_seen_r && buf_in_ready;
  assign frame_ready = buf_in_ready;

  // loading sequence, channel latches and polarity
  always_comb begin
    chan_nxt        = chan_r;
    pair_cnt_nxt    = pair_cnt_r;
    load_dir_nxt    = load_dir_r;
    pending_pol_nxt = pending_pol_r;
    applied_pol_nxt = applied_pol_r;
    frame_in        = '0;
    if (pair_cnt_r < 3'(PAIR_COUNT)) begin
      chan_nxt[chan_index(load_dir_r, {pair_cnt_r, 1'b0})] = rise_word_r;
      chan_nxt[chan_index(load_dir_r, {pair_cnt_r, 1'b1})] = fall_word_r;
      pair_cnt_nxt = pair_cnt_r + 3'h1;
    end
    if (xfer_take) begin
      pair_cnt_nxt    = '0;
      load_dir_nxt    = load_dir_select;
      pending_pol_nxt = polarity_invert;
      applied_pol_nxt = pending_pol_r;
    end
    for (int i = 0; i < CH_COUNT; i++) begin
      frame_in[i*WORD_W +: WORD_W] = chan_nxt[i];
    end
    frame_in[FRAME_W-1] = applied_pol_nxt;
  end

  // pixel path registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CH_COUNT; i++) begin
        chan_r[i] <= WORD_RST;
      end
      rise_word_r   <= WORD_RST;
      pair_cnt_r    <= PAIR_IDLE_RST;
      load_dir_r    <= 1'b0;
      strobe_seen_r <= 1'b0;
      pending_pol_r <= 1'b0;
      applied_pol_r <= 1'b0;
      started_r     <= 1'b0;
    end else begin
      chan_r        <= chan_nxt;
      rise_word_r   <= pixel_data_bus;
      pair_cnt_r    <= pair_cnt_nxt;
      load_dir_r    <= load_dir_nxt;
      strobe_seen_r <= transfer_start_strobe;
      pending_pol_r <= pending_pol_nxt;
      applied_pol_r <= applied_pol_nxt;
      started_r     <= started_r || xfer_take;
    end
  end

  // output buffer holds moved frames until the receiver takes them
  frame_skid_buffer #(
    .W     (FRAME_W),
    .DEPTH (BUF_DEPTH)
  ) u_out_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (xfer_take),
    .in_ready  (buf_in_ready),
    .in_data   (frame_in),
    .out_valid (video_valid),
    .out_ready (video_ready),
    .out_data  (frame_out)
  );

  assign video_output       = frame_out[FRAME_W-2:0];
  assign video_above_center = frame_out[FRAME_W-1];

  // ************************************************************
  // thermal switch and serial dac
  // ************************************************************
  // serial pins and thermal switch come from outside, two flops first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      therm_sync_r   <= '0;
      sclk_sync_r    <= 3'h7;  // idle high, no false rise after reset
      load_en_sync_r <= 3'h7;
      sdata_sync_r   <= '0;
    end else begin
      therm_sync_r   <= {therm_sync_r[0], thermal_protect_enable};
      sclk_sync_r    <= {sclk_sync_r[1:0], serial_clock};
      load_en_sync_r <= {load_en_sync_r[1:0], serial_load_enable};
      sdata_sync_r   <= {sdata_sync_r[0], serial_data_in};
    end
  end

  assign thermal_protect_active = therm_sync_r[1];
  assign sclk_rise    = sclk_sync_r[1] && !sclk_sync_r[2];
  assign load_en_rise = load_en_sync_r[1] && !load_en_sync_r[2];
  assign load_en_fall = !load_en_sync_r[1] && load_en_sync_r[2];

  // shift while enable low, commit on enable rise
  always_comb begin
    shift_nxt    = shift_r;
    sclk_cnt_nxt = sclk_cnt_r;
    aux_nxt      = aux_dac_output;
    aux_upd_nxt  = 1'b0;
    if (load_en_fall) begin
      sclk_cnt_nxt = '0;
    end else if (sclk_rise && !load_en_sync_r[1]) begin
      shift_nxt = {shift_r[SER_W-2:0], sdata_sync_r[1]};
      if (sclk_cnt_r != 2'(SER_MIN_CLKS)) begin
        sclk_cnt_nxt = sclk_cnt_r + 2'h1;
      end
    end
    if (load_en_rise && sclk_cnt_r == 2'(SER_MIN_CLKS)) begin
      aux_nxt     = shift_r;
      aux_upd_nxt = 1'b1;
    end
  end

  // serial registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_r        <= SER_RST;
      sclk_cnt_r     <= '0;
      aux_dac_output <= SER_RST;
      aux_dac_update <= 1'b0;
    end else begin
      shift_r        <= shift_nxt;
      sclk_cnt_r     <= sclk_cnt_nxt;
      aux_dac_output <= aux_nxt;
      aux_dac_update <= aux_upd_nxt;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_strobe_only_sampled: assert property (!$past(transfer_start_strobe) |-> !xfer_take)
    else $error("transfer taken without sampled strobe");
  a_transfer_restarts: assert property (xfer_take |=> pair_cnt_r == 3'h0 && video_valid)
    else $error("transfer did not restart loading or queue frame");
  a_ascend_first: assert property (pair_cnt_r == 3'h0 && !load_dir_r
                                   |=> chan_r[0] == $past(rise_word_r) && chan_r[1] == $past(fall_word_r))
    else $error("ascending load missed channel 0 or 1");
  a_descend_first: assert property (pair_cnt_r == 3'h0 && load_dir_r
                                    |=> chan_r[11] == $past(rise_word_r) && chan_r[10] == $past(fall_word_r))
    else $error("descending load missed channel 11 or 10");
  a_invert_capture: assert property (xfer_take |=> pending_pol_r == $past(polarity_invert))
    else $error("invert input not captured at transfer");
  a_invert_delay: assert property (xfer_take ##1 (!xfer_take)[*2] |=> applied_pol_r == $past(pending_pol_r, 3))
    else $error("applied polarity not one transfer late");
  a_pol_hold: assert property (!xfer_take |=> $stable(applied_pol_r))
    else $error("applied polarity changed without transfer");
  a_thermal_follow: assert property ($past(rst_n, 2) |-> thermal_protect_active == $past(thermal_protect_enable, 2))
    else $error("thermal enable not following switch");
  a_six_clock_load: assert property (xfer_take ##1 (!xfer_take)[*6] |=> pair_cnt_r == 3'(PAIR_COUNT))
    else $error("loading sequence not six clocks");
  a_aux_commit: assert property (load_en_rise && sclk_cnt_r == 2'(SER_MIN_CLKS)
                                 |=> aux_dac_update && aux_dac_output == $past(shift_r))
    else $error("aux dac not committed on enable rise");
  a_short_load_ignored: assert property (load_en_rise && sclk_cnt_r != 2'(SER_MIN_CLKS) |=> $stable(aux_dac_output))
    else $error("aux dac updated after short load");
  a_default_until_start: assert property (!started_r |-> !video_valid)
    else $error("frame shown before first transfer");

endmodule

/* verification/video_source_model.sv */
module video_source_model
  import column_driver_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         frame_ready,
  output logic [WORD_W-1:0] pixel_data_bus,
  output logic              transfer_start_strobe,
  output logic              load_dir_select,
  output logic              polarity_invert
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****
  // source side of the pixel bus
  // ****
  initial begin
    pixel_data_bus = WORD_RST;
    transfer_start_strobe = 1'b0;
    load_dir_select = 1'b0;
    polarity_invert = 1'b0;
  end

  // one strobe, then twelve words on both edges
  task automatic send_frame(input logic [CH_COUNT*WORD_W-1:0] w, input logic sel, input logic pol);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (frame_ready !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    transfer_start_strobe = 1'b1;
    load_dir_select = sel;
    polarity_invert = pol;
    @(posedge clk_sys);
    #1;
    transfer_start_strobe = 1'b0;
    pixel_data_bus = w[0+:WORD_W];
    for (int k = 0; k < PAIR_COUNT; k++) begin
      @(posedge clk_sys);
      #1;
      pixel_data_bus = w[(2*k+1)*WORD_W+:WORD_W];
      if (k < PAIR_COUNT-1) begin
        @(negedge clk_sys);
        #1;
        pixel_data_bus = w[(2*k+2)*WORD_W+:WORD_W];
      end
    end
    @(negedge clk_sys);
    #1;
    pixel_data_bus = ~pixel_data_bus; // hold time over: stale value inverted
  endtask
endmodule

/* verification/decimating_column_driver_input_control_tb_top.sv */
module decimating_column_driver_input_control_tb_top
  import column_driver_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int VW = CH_COUNT*WORD_W;
  logic              clk_sys, rst_n, video_ready, serial_clock, serial_load_enable, serial_data_in;
  logic              thermal_protect_enable, transfer_start_strobe, load_dir_select, polarity_invert;
  logic              frame_ready, video_valid, video_above_center, thermal_protect_active, aux_dac_update;
  logic [WORD_W-1:0] pixel_data_bus;
  logic [VW-1:0]     video_output;
  logic [SER_W-1:0]  aux_dac_output, sh, dac_exp;
  logic [VW:0]       exp_q[$];
  int                bad_count, cmp_count, seed, rdy_th;

  // ****
  // design, source and clock
  // ****
  column_driver_input dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .pixel_data_bus(pixel_data_bus),
    .transfer_start_strobe(transfer_start_strobe), .load_dir_select(load_dir_select),
    .polarity_invert(polarity_invert), .thermal_protect_enable(thermal_protect_enable),
    .serial_clock(serial_clock), .serial_load_enable(serial_load_enable), .serial_data_in(serial_data_in),
    .frame_ready(frame_ready), .video_valid(video_valid), .video_ready(video_ready),
    .video_output(video_output), .video_above_center(video_above_center),
    .thermal_protect_active(thermal_protect_active), .aux_dac_output(aux_dac_output),
    .aux_dac_update(aux_dac_update));

  video_source_model src_u (.clk_sys(clk_sys), .frame_ready(frame_ready), .pixel_data_bus(pixel_data_bus),
    .transfer_start_strobe(transfer_start_strobe), .load_dir_select(load_dir_select),
    .polarity_invert(polarity_invert));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // compare and report
  task automatic check(input string what, input logic [VW:0] seen, input logic [VW:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // receiver with random stalls, none once rdy_th is 4
  always @(posedge clk_sys) begin
    #1 video_ready = ($random(seed) & 3) < rdy_th;
  end

  // frame monitor pops the oldest note
  always @(posedge clk_sys) begin
    if (video_valid === 1'b1 && video_ready === 1'b1) begin
      if (exp_q.size() > 0) begin
        check("frame", {video_above_center, video_output}, exp_q.pop_front());
      end else begin
        check("frame_extra", 1, 0);
      end
    end
  end

  // serial word, msb first, n clocks
  task automatic ser_word(input logic [15:0] d, input int n);
    int k;
    @(posedge clk_sys);
    #1 serial_load_enable = 1'b0;
    for (k = n-1; k >= 0; k--) begin
      repeat (4) @(posedge clk_sys);
      #1 serial_data_in = d[k];
      serial_clock = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 serial_clock = 1'b1;
      sh = {sh[SER_W-2:0], d[k]};
    end
    repeat (4) @(posedge clk_sys);
    #1 serial_load_enable = 1'b1;
    if (n >= SER_MIN_CLKS) dac_exp = sh;
    k = 0;
    while (aux_dac_update !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1 k++;
    end
    check("aux_dac", {k < 20, aux_dac_output}, {n >= SER_MIN_CLKS, dac_exp});
  endtask

  initial begin
    logic [VW-1:0] w, e;
    logic          sel, pol;
    int            n;
    seed = 36082;
    rdy_th = 1;
    rst_n = 1'b0;
    video_ready = 1'b0;
    thermal_protect_enable = 1'b0;
    serial_clock = 1'b1;
    serial_load_enable = 1'b1;
    serial_data_in = 1'b0;
    sh = SER_RST;
    dac_exp = SER_RST;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    check("reset", {frame_ready, video_valid, video_above_center, thermal_protect_active, aux_dac_update,
      aux_dac_output}, {5'b10000, SER_RST});
    $display("test reset done");
    exp_q.push_back({1'b0, {VW{1'b0}}});
    for (int f = 0; f < 8; f++) begin
      if (f == 4) rdy_th = 4;
      sel = f[0];
      pol = f[1] ^ f[2];
      for (int s = 0; s < CH_COUNT; s++) begin
        w[s*WORD_W+:WORD_W] = $random(seed);
        e[(sel ? CH_COUNT-1-s : s)*WORD_W+:WORD_W] = w[s*WORD_W+:WORD_W];
      end
      exp_q.push_back({pol, e});
      src_u.send_frame(w, sel, pol);
    end
    src_u.send_frame(w, 1'b0, 1'b0);
    n = 0;
    while (exp_q.size() > 0 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    check("frames_left", exp_q.size(), 0);
    $display("test video done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1 thermal_protect_enable = $random(seed);
      repeat (2) @(posedge clk_sys);
      #1 check("thermal", thermal_protect_active, thermal_protect_enable);
    end
    $display("test thermal done");
    ser_word($random(seed), 12);
    ser_word($random(seed), 14);
    ser_word($random(seed), 2);
    ser_word($random(seed), 3);
    $display("test serial done");
    tally_and_finish();
  end

  // watchdog
  initial begin
    #300us;
    bad_count++;
    tally_and_finish();
  end
endmodule
